// >>> core/ssp_regs.vh
/*
 header of constants for the serial command and fault port.
 assumes inclusion by bare name from the design files under core/.
*/
// Overview of operation
// - transfer only while chip select low
// - chip select rise latches command word
// - chip select fall captures fault status
// - deselected: ignore clock, data; output released
// - sample serial input on clock fall
// - shift serial output on clock rise
// - input register holds one 24-bit word
// - header: any-fault, overvoltage, six zeros
// - then output 15 down to 0 status
// - msb first, first in first out
// - status one means fault present
// - fault bit set after qualification time
// - low logic supply holds reset, outputs off
// - seven instructions decoded from command word
// - bits 23..18 select, 15..0 settings
// - overvoltage sets overvoltage and any-fault
`ifndef SSP_REGS_VH
`define SSP_REGS_VH

// ==========================================================
// word layout
`define SSP_WORD_BITS      24
`define SSP_SEL_MSB        23
`define SSP_SEL_LSB        18
`define SSP_ANY_FAULT_BIT  23
`define SSP_OVERVOLT_BIT   22
`define SSP_NUM_CMDS       7

// ==========================================================
// reset values
`define SSP_WORD_RESET     24'h00_0000
`define SSP_OUT_RESET      16'h0000

// ==========================================================
// timing
`define SSP_CLK_MHZ        200
`define SSP_QUAL_MIN_US    100
`define SSP_QUAL_CYCLES    (`SSP_QUAL_MIN_US * `SSP_CLK_MHZ)

`endif

// >>> core/ssp_fault_qual.v
/*
 per-output fault persistence filter.
 assumes raw fault levels already synchronised to clock.
*/
`timescale 1ns/1ps
`include "ssp_regs.vh"
module ssp_fault_qual
#(
   parameter N      = 16,
   parameter CYCLES = `SSP_QUAL_CYCLES
)
(
   input  wire         clock,
   input  wire         rst,
   input  wire [N-1:0] raw_fault,
   output reg  [N-1:0] qual_fault
);

   // ========================================================
   // counters
   reg [24:0] count [0:N-1];
   integer    i;

   // a fault that drops even briefly restarts its timer
   always @(posedge clock)
   begin
      for (i = 0; i < N; i = i + 1)
      begin
         if (rst || !raw_fault[i])
         begin
            count[i]      <= 25'h000_0000;
            qual_fault[i] <= 1'b0;
         end
         else if (count[i] >= CYCLES[24:0] - 25'h000_0001)
            qual_fault[i] <= 1'b1;
         else
            count[i] <= count[i] + 25'h000_0001;
      end
   end
endmodule // ssp_fault_qual

// >>> core/ssp_port.v
/*
 serial command and fault port of a 16-channel low-side switch.
 a 24-bit command word is shifted in, msb first, on serial clock
 falls while chip select is low; the 24-bit fault word is shifted
 out on serial clock rises in the same frame. the fault word is
 captured when chip select falls and the command is acted on when
 chip select rises. selector 0 drives the output latches directly;
 every other selector is handed on through cmd_select and
 cmd_settings, with cmd_valid marking the seven known codes.
 per-output faults pass a persistence filter before they reach
 the fault word.
 assumes a master that obeys the select, clock and spacing limits:
 serial clock low at every select edge, serial clock slow enough
 for the synchronisers, and accesses spaced beyond the fault
 qualification time. serial pins, fault levels, overvoltage and
 the supply monitor are asynchronous and pass two flip-flops.
*/
`timescale 1ns/1ps
`include "ssp_regs.vh"
module ssp_port
#(
   parameter NOUT        = 16,
   parameter QUAL_CYCLES = `SSP_QUAL_CYCLES
)
(
   input  wire              clock,
   input  wire              rst,
   input  wire              interface_logic_supply_ok,
   input  wire              chip_select_n,
   input  wire              serial_clock,
   input  wire              serial_in,
   output reg               serial_out,
   output wire              serial_out_oe,
   input  wire [NOUT-1:0]   raw_fault,
   input  wire              overvoltage,
   output reg  [NOUT-1:0]   output_on,
   output reg  [5:0]        cmd_select,
   output reg  [NOUT-1:0]   cmd_settings,
   output reg               cmd_strobe,
   output reg               cmd_valid
);

   // ========================================================
   // synchronisers
   reg [1:0] cs_sync;
   reg [1:0] sck_sync;
   reg [1:0] si_sync;
   reg [1:0] sup_sync;
   reg       cs_prev;
   // fault levels come from analog detectors, so they are synchronised
   reg [NOUT-1:0] raw_sync0;
   reg [NOUT-1:0] raw_sync1;
   reg       sck_prev;
   wire      hold_rst;

   always @(posedge clock)
   begin
      cs_sync  <= {cs_sync[0], chip_select_n};
      sck_sync <= {sck_sync[0], serial_clock};
      si_sync  <= {si_sync[0], serial_in};
      sup_sync <= {sup_sync[0], interface_logic_supply_ok};
      raw_sync0 <= raw_fault;
      raw_sync1 <= raw_sync0;
   end

   assign hold_rst = rst || !sup_sync[1];

   // ========================================================
   // edge detection
   wire selected = !cs_sync[1];
   wire cs_fall  = cs_prev && !cs_sync[1];
   wire cs_rise  = !cs_prev && cs_sync[1];
   wire sck_fall = selected && sck_prev && !sck_sync[1];
   wire sck_rise = selected && !sck_prev && sck_sync[1];

   always @(posedge clock)
   begin
      if (hold_rst)
      begin
         // idle pin levels, so no false edge follows reset
         cs_prev  <= 1'b1;
         sck_prev <= 1'b0;
      end
      else
      begin
         cs_prev  <= cs_sync[1];
         sck_prev <= sck_sync[1];
      end
   end

   // ========================================================
   // fault qualification
   wire [NOUT-1:0] qual;

   ssp_fault_qual
   #(
      .N      (NOUT),
      .CYCLES (QUAL_CYCLES)
   )
   u_qual
   (
      .clock      (clock),
      .rst        (hold_rst),
      .raw_fault  (raw_sync1),
      .qual_fault (qual)
   );

   reg ov_sync0;
   reg ov_sync1;
   always @(posedge clock)
   begin
      ov_sync0 <= overvoltage;
      ov_sync1 <= ov_sync0;
   end

   function is_known_cmd;
      input [5:0] sel;
      begin
         is_known_cmd = (sel < `SSP_NUM_CMDS);
      end
   endfunction

   function [5:0] sel_of;
      input [`SSP_WORD_BITS-1:0] word;
      begin
         sel_of = word[`SSP_SEL_MSB:`SSP_SEL_LSB];
      end
   endfunction

   // header zeros follow NOUT so the fault word stays 24 bits wide
   localparam HDR_ZEROS = `SSP_WORD_BITS - 2 - NOUT;

   function [`SSP_WORD_BITS-1:0] status_of;
      input            any;
      input            ov;
      input [NOUT-1:0] q;
      begin
         status_of = {any, ov, {HDR_ZEROS{1'b0}}, q};
      end
   endfunction

   // ========================================================
   // shift registers
   reg [`SSP_WORD_BITS-1:0] in_shift;
   reg [`SSP_WORD_BITS-1:0] out_shift;

   // captured word: any-fault, overvoltage, six zeros, outputs 15..0
   wire any_fault = ov_sync1 || (|qual);
   wire [`SSP_WORD_BITS-1:0] status_word =
      status_of(any_fault, ov_sync1, qual);

   always @(posedge clock)
   begin
      if (hold_rst)
      begin
         in_shift  <= `SSP_WORD_RESET;
         out_shift <= `SSP_WORD_RESET;
         serial_out <= 1'b0;
      end
      else
      begin
         if (cs_fall)
         begin
            out_shift  <= status_word;
            serial_out <= status_word[`SSP_WORD_BITS-1];
         end
         else if (sck_rise)
         begin
            // first rise after select keeps bit 23, later ones advance
            serial_out <= out_shift[`SSP_WORD_BITS-1];
            out_shift  <= {out_shift[`SSP_WORD_BITS-2:0], in_shift[0]};
         end
         if (sck_fall)
            in_shift <= {in_shift[`SSP_WORD_BITS-2:0], si_sync[1]};
      end
   end

   assign serial_out_oe = selected && !hold_rst;

   // ========================================================
   // command latch
   always @(posedge clock)
   begin
      if (hold_rst)
      begin
         output_on    <= `SSP_OUT_RESET;
         cmd_select   <= 6'b00_0000;
         cmd_settings <= `SSP_OUT_RESET;
         cmd_strobe   <= 1'b0;
         cmd_valid    <= 1'b0;
      end
      else
      begin
         cmd_strobe <= cs_rise;
         if (cs_rise)
         begin
            cmd_select   <= sel_of(in_shift);
            cmd_settings <= in_shift[NOUT-1:0];
            cmd_valid    <= is_known_cmd(sel_of(in_shift));
            // only on/off words touch the outputs; other codes are
            // left to logic outside this port
            if (sel_of(in_shift) == 6'h00)
               output_on <= in_shift[NOUT-1:0];
         end
      end
   end
endmodule // ssp_port

// >>> testbench/ssp_props.sv
/*
 checker on the serial port's output enable and user-side outputs.
 assumes binding to ssp_port, one clock domain.
*/
`timescale 1ns/1ps
module ssp_props
#(
   parameter NOUT = 16
)
(
   input wire            clock,
   input wire            rst,
   input wire            interface_logic_supply_ok,
   input wire            chip_select_n,
   input wire            serial_out_oe,
   input wire [NOUT-1:0] output_on,
   input wire [5:0]      cmd_select,
   input wire [NOUT-1:0] cmd_settings,
   input wire            cmd_strobe,
   input wire            cmd_valid
);
   default clocking @(posedge clock);
   endclocking
   default disable iff (rst);
   // ==========================================================
   // assertions
   oe_off_a: assert property (chip_select_n [*4] |-> !serial_out_oe)
      else $error("output driven while deselected");
   oe_on_a: assert property ((!chip_select_n && interface_logic_supply_ok)
      [*6] |-> serial_out_oe)
      else $error("output not driven while selected");
   rst_clear_a: assert property ($fell(rst) |-> output_on == 16'h0000
      && !cmd_strobe && !cmd_valid)
      else $error("outputs on in reset");
   supply_off_a: assert property (!interface_logic_supply_ok [*4]
      |-> output_on == 16'h0000 && !serial_out_oe)
      else $error("outputs on with supply low");
   strobe_pulse_a: assert property (cmd_strobe |=> !cmd_strobe)
      else $error("strobe longer than one cycle");
   strobe_rise_a: assert property (($rose(chip_select_n)
      && interface_logic_supply_ok) |-> ##[2:5] cmd_strobe)
      else $error("no strobe after select rise");
   sel_valid_a: assert property (cmd_strobe
      |-> cmd_valid == (cmd_select < 6'h07))
      else $error("valid flag wrong");
   out_latch_a: assert property ((cmd_strobe && cmd_select == 6'h00)
      |-> ##[0:1] output_on == cmd_settings)
      else $error("outputs not latched");
endmodule // ssp_props

// >>> testbench/ssp_mst.sv
/*
 behavioural serial master facing the port.
 assumes so_line is the resolved serial output wire.
*/
`timescale 1ns/1ps
module ssp_mst
(
   output reg  chip_select_n,
   output reg  serial_clock,
   output reg  serial_in,
   input  wire so_line
);
   // clock idles low, data rests at its pull-down level
   initial
   begin
      chip_select_n = 1'b1;
      serial_clock = 1'b0;
      serial_in = 1'b0;
   end
   // ==========================================================
   // one 24-bit frame, 80 ns clock period
   task xfer(input [23:0] cmd, output [23:0] rsp);
      integer i;
      begin
         chip_select_n = 1'b0;
         #80;
         for (i = 23; i >= 0; i = i - 1)
         begin
            #20 serial_in = cmd[i];
            #20 serial_clock = 1'b1;
            #40 serial_clock = 1'b0;
            rsp[i] = so_line;
         end
         #60 chip_select_n = 1'b1;
         serial_in = 1'b0;
      end
   endtask
endmodule // ssp_mst

// >>> testbench/tb_top.sv
/*
 top testbench for the serial command and fault port.
 assumes the design files are compiled first.
*/
`timescale 1ns/1ps
module tb_top;
   reg         clock, rst, interface_logic_supply_ok, overvoltage;
   reg  [15:0] raw_fault, exp_on;
   reg  [23:0] rsp;
   wire        chip_select_n, serial_clock, serial_in, serial_out;
   wire        serial_out_oe, cmd_strobe, cmd_valid;
   wire [15:0] output_on, cmd_settings;
   wire [5:0]  cmd_select;
   wire        so_line = serial_out_oe ? serial_out : 1'bz;
   integer     n_mismatch = 0;
   integer     n_tests = 0;
   integer     s;
   ssp_port
   #(
      .QUAL_CYCLES (20)
   )
   DUT
   (
      .clock                     (clock),
      .rst                       (rst),
      .interface_logic_supply_ok (interface_logic_supply_ok),
      .chip_select_n             (chip_select_n),
      .serial_clock              (serial_clock),
      .serial_in                 (serial_in),
      .serial_out                (serial_out),
      .serial_out_oe             (serial_out_oe),
      .raw_fault                 (raw_fault),
      .overvoltage               (overvoltage),
      .output_on                 (output_on),
      .cmd_select                (cmd_select),
      .cmd_settings              (cmd_settings),
      .cmd_strobe                (cmd_strobe),
      .cmd_valid                 (cmd_valid)
   );
   ssp_mst MST (.chip_select_n, .serial_clock, .serial_in, .so_line);
   initial clock = 1'b0;
   always #2.5 clock = ~clock;
   // ==========================================================
   // tasks
   task chk(input string nm, input [23:0] e, input [23:0] g);
      begin
         n_tests = n_tests + 1;
         if (g !== e)
         begin
            n_mismatch = n_mismatch + 1;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   task stop_test;
      begin
         if (n_mismatch == 0 && n_tests > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask
   task go(input [23:0] cmd, input [23:0] e);
      integer k;
      begin
         MST.xfer(cmd, rsp);
         chk("status", e, rsp);
         for (k = 0; k < 20 && cmd_strobe !== 1'b1; k = k + 1)
            @(negedge clock);
         chk("strobe", 24'h00_0001, {23'h0, cmd_strobe});
         if (cmd_strobe !== 1'b1)
            stop_test;
         repeat (25) @(negedge clock);
      end
   endtask
   // ==========================================================
   // sequence
   initial
   begin
      rst = 1'b1;
      interface_logic_supply_ok = 1'b1;
      overvoltage = 1'b0;
      raw_fault = 16'h8001;
      repeat (2) @(negedge clock);
      rst = 1'b0;
      chk("output_on", 24'h00_0000, output_on);
      repeat (40) @(negedge clock);
      go(24'h00_A5C3, 24'h80_8001);
      chk("output_on", 24'h00_A5C3, output_on);
      overvoltage = 1'b1;
      exp_on = 16'hA5C3;
      // selectors 7 down to 0, back to back, ending with the on/off word
      for (s = 7; s >= 0; s = s - 1)
      begin
         go({s[5:0], 2'b00, 16'h5A00 | s[15:0]}, 24'hC0_8001);
         chk("cmd", {s < 7, s[5:0], 16'h5A00 | s[15:0]},
            {cmd_valid, cmd_select, cmd_settings});
         if (s == 0)
            exp_on = 16'h5A00;
         chk("output_on", exp_on, output_on);
      end
      // a new fault is not reported before it has been qualified
      raw_fault = 16'h8003;
      go(24'h00_5A00, 24'hC0_8001);
      go(24'h00_5A00, 24'hC0_8003);
      overvoltage = 1'b0;
      raw_fault = 16'h0000;
      repeat (4) @(negedge clock);
      go(24'h00_0000, 24'h00_0000);
      chk("output_on", 24'h00_0000, output_on);
      interface_logic_supply_ok = 1'b0;
      repeat (6) @(negedge clock);
      chk("output_on", 24'h00_0000, output_on);
      stop_test;
   end
endmodule // tb_top
bind ssp_port ssp_props #(.NOUT(NOUT)) u_props (.clock, .rst,
   .interface_logic_supply_ok, .chip_select_n, .serial_out_oe, .output_on,
   .cmd_select, .cmd_settings, .cmd_strobe, .cmd_valid);
